// ---- sim/dvl_checker_monitor.sv ----
// Port-level assertions for the dynamic core-voltage limit checker
`timescale 1ns/1ps
module dvl_checker_monitor import dvl_pkg::*; #(
  parameter int PERIOD_CYC = 2000,
  parameter int WINDOW_CYC = 512
) (
  // Clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // APB
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Codes and results
  input wire logic [5:0]     cpu_one_voltage_code_lines,
  input wire logic [5:0]     cpu_two_voltage_code_lines,
  input wire logic [NCH-1:0] err_event,
  input wire logic           irq
);
  ////////////////////////////////////////
  int   gap;
  int   run_one;
  int   run_two;
  logic seen;
  wire  acc     = psel && penable && pready;
  wire  ien_wr  = acc && pwrite && paddr == OFS_IEN;
  wire  clr_all = acc && pwrite && paddr == OFS_ICLR && pwdata[3:0] == 4'hF;
  wire  off_one = cpu_one_voltage_code_lines[5:1] == 5'h1F;
  wire  off_two = cpu_two_voltage_code_lines[5:1] == 5'h1F;
  wire  any_ev  = err_event != '0;
  // Runs are counted on the raw lines, so the skew filter delay is allowed for
  localparam int OFF_MAX = WINDOW_CYC + SKEW_CYC + 8;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap     <= 0;
      seen    <= 1'b0;
      run_one <= 0;
      run_two <= 0;
    end else begin
      gap     <= any_ev ? 1 : gap + 1;
      seen    <= seen || any_ev;
      run_one <= off_one ? run_one + 1 : 0;
      run_two <= off_two ? run_two + 1 : 0;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_event_pulse: assert property (any_ev |=> !any_ev)
    else $error("error event longer than one cycle");
  a_event_period: assert property (any_ev && seen |-> gap % PERIOD_CYC == 0)
    else $error("error events not a whole period apart");
  a_off_skip_one: assert property (err_event[0] |-> run_one <= OFF_MAX)
    else $error("channel one event after an off window");
  a_off_skip_two: assert property (err_event[1] |-> run_two <= OFF_MAX)
    else $error("channel two event after an off window");
  // The interrupt and the event flop load on the same edge, so both rise together
  a_irq_cause: assert property ($rose(irq) |-> any_ev || $past(any_ev) || $past(ien_wr)
                                || $past(ien_wr, 2))
    else $error("interrupt rose without a cause");
  a_irq_clear: assert property (clr_all ##1 !any_ev |=> !irq)
    else $error("interrupt stayed after full clear");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  // The first access edge only loads ready, so it is seen one edge later
  a_ready_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
    else $error("ready not after one wait state");
  a_err_decode: assert property (acc |-> pslverr == (paddr[7:2] > 6'h07))
    else $error("slave error does not match address");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
endmodule // dvl_checker_monitor

// ---- sim/dvl_cpu_adc_model.sv ----
// Processor code drivers and converter model facing the limit checker
`timescale 1ns/1ps
module dvl_cpu_adc_model #(
  parameter logic [5:0] CODE_ONE_INIT = 6'h3D,
  parameter logic [5:0] CODE_TWO_INIT = 6'h00,
  parameter int         STEP_CYC      = 1000,
  parameter int         CONV_CYC      = 64,
  parameter int         GLITCH_DLY    = 1500
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests from the bench
  input  wire logic [5:0] tgt_one,
  input  wire logic [5:0] tgt_two,
  input  wire logic [7:0] rd_one,
  input  wire logic [7:0] rd_two,
  input  wire logic       glitch,
  // Lines into the block
  output logic      [5:0] code_one,
  output logic      [5:0] code_two,
  output logic      [7:0] adc_one,
  output logic      [7:0] adc_two,
  output logic            conv_valid
);
  logic [5:0] cur_one;
  logic [5:0] cur_two;
  int         t_one;
  int         t_two;
  int         tconv;
  int         tgl;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_one    <= CODE_ONE_INIT;
      cur_two    <= CODE_TWO_INIT;
      t_one      <= STEP_CYC;
      t_two      <= STEP_CYC;
      tconv      <= 0;
      tgl        <= 0;
      conv_valid <= 1'b0;
      adc_one    <= 8'h00;
      adc_two    <= 8'h00;
    end else begin
      t_one <= t_one + 1;
      t_two <= t_two + 1;
      // One step, then a rest of at least 5 us
      if (t_one >= STEP_CYC && cur_one != tgt_one) begin
        cur_one <= (tgt_one > cur_one) ? cur_one + 6'h01 : cur_one - 6'h01;
        t_one   <= 0;
      end
      if (t_two >= STEP_CYC && cur_two != tgt_two) begin
        cur_two <= (tgt_two > cur_two) ? cur_two + 6'h01 : cur_two - 6'h01;
        t_two   <= 0;
      end
      tconv      <= (tconv == CONV_CYC - 1) ? 0 : tconv + 1;
      conv_valid <= tconv == 0;
      // Between conversions the buses toggle, so a stray latch shows up
      adc_one    <= (tconv == 0) ? rd_one : ~adc_one;
      adc_two    <= (tconv == 0) ? rd_two : ~adc_two;
      tgl        <= glitch ? GLITCH_DLY + 3 : (tgl > 0 ? tgl - 1 : 0);
    end
  end

  // Line skew: channel two briefly shows an off code
  assign code_one = cur_one;
  assign code_two = (tgl > 0 && tgl <= 3) ? 6'h3F : cur_two;
endmodule // dvl_cpu_adc_model

// ---- sim/tb_dvl_checker.sv ----
// Self-checking testbench of the dynamic core-voltage limit checker
`timescale 1ns/1ps
module tb_dvl_checker import dvl_pkg::*;;
  localparam int P = 2000;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, glitch = 0;
  logic [7:0]  paddr = '0, rd1 = '0, rd2 = '0;
  logic [31:0] pwdata = '0;
  logic [5:0]  tg1 = 6'h3D, tg2 = 6'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr, conv_valid, irq;
  wire  [5:0]  code1, code2;
  wire  [7:0]  ad1, ad2;
  wire  [NCH-1:0] err_event;
  int          fails = 0, comparisons = 0, cyc = 0, seed = 88379;
  logic [32:0] rdq[$], e;
  logic [1:0]  evq[$];
  logic [7:0]  r1 [4];
  logic [5:0]  t1 [4] = '{6'h3D, 6'h3E, 6'h3D, 6'h3D};
  logic [5:0]  t2 [4] = '{6'h00, 6'h01, 6'h01, 6'h01};
  logic [7:0]  r2 [4] = '{8'hFF, 8'hFF, 8'hF4, 8'h00};
  logic [1:0]  ct [4] = '{2'h3, 2'h3, 2'h3, 2'h1};
  logic [7:0]  up [4] = '{8'h08, 8'h01, 8'h01, 8'h01};
  logic [3:0]  ie [4] = '{4'h0, 4'hF, 4'h8, 4'h4};
  logic [1:0]  ev [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
  logic [3:0]  st [4] = '{4'h1, 4'h4, 4'h8, 4'h2};
  logic [31:0] av [4] = '{32'h0000FF85, 32'h0001FD00, 32'h0000FD85, 32'h0000FD85};

  dvl_checker #(.PERIOD_CYC(P), .WINDOW_CYC(512)) dvl_checker_i (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_one_voltage_code_lines(code1), .cpu_two_voltage_code_lines(code2),
    .core_voltage_input_one(ad1), .core_voltage_input_two(ad2), .conv_valid(conv_valid),
    .err_event(err_event), .irq(irq));
  dvl_cpu_adc_model dvl_cpu_adc_model_i (
    .pclk(pclk), .presetn(presetn), .tgt_one(tg1), .tgt_two(tg2), .rd_one(rd1),
    .rd_two(rd2), .glitch(glitch), .code_one(code1), .code_two(code2), .adc_one(ad1),
    .adc_two(ad2), .conv_valid(conv_valid));

  ////////////////////////////////////////
  task automatic chk(input string n, input logic [32:0] x, input logic [32:0] s);
    comparisons++;
    if (s !== x) begin
      $display("Error %s expected %h seen %h", n, x, s);
      fails++;
    end
  endtask

  task automatic summarize;
    $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Expected answer is queued before the access starts
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    int n;
    n = 0;
    rdq.push_back(x);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk) n++; while (pready !== 1'b1 && n < 20);
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin fails++; summarize(); end
  endtask

  ////////////////////////////////////////
  initial forever #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= presetn ? cyc + 1 : 0;
    if (psel && penable && pready === 1'b1 && rdq.size() > 0) begin
      e = rdq.pop_front();
      if (pwrite) chk("pslverr", {e[32], 32'h0}, {pslverr, 32'h0});
      else chk("prdata", e, {pslverr, prdata});
    end
    if (err_event !== 2'b00)
      chk("err_event", evq.size() ? evq.pop_front() : 2'b00, err_event);
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CTRL, 0, {31'h0, 2'h3});
    apb(0, OFS_LIM1, 0, {17'h0, 16'h0808});
    apb(0, OFS_LIM2, 0, {17'h0, 16'h0808});
    apb(0, OFS_IEN, 0, 33'h0);
    apb(1, OFS_STAT, 32'hF, 33'h0);
    apb(0, OFS_STAT, 0, 33'h0);
    apb(0, OFS_ICLR, 0, 33'h0);
    apb(0, 8'h20, 0, {1'b1, 32'h0});
    apb(1, 8'h24, 32'hFFFFFFFF, {1'b1, 32'h0});
    apb(1, OFS_LIM1, 32'h0808, 33'h0);
    $display("Test registers done");
    for (int k = 0; k < 5; k++) begin
      while (cyc < k * P + 100) @(posedge pclk);
      if (k > 0) begin
        apb(0, OFS_STAT, 0, {29'h0, st[k-1]});
        apb(0, OFS_AVG, 0, {1'b0, av[k-1]});
        apb(0, OFS_READ, 0, {17'h0, r2[k-1], r1[k-1]});
        chk("irq", {32'h0, |(st[k-1] & ie[k-1])}, {32'h0, irq});
        apb(1, OFS_ICLR, 32'hF, 33'h0);
        repeat (3) @(posedge pclk);
        chk("irq cleared", 33'h0, {32'h0, irq});
        $display("Test period %0d done", k - 1);
      end
      if (k < 4) begin
        apb(1, OFS_CTRL, {30'h0, ct[k]}, 33'h0);
        apb(1, OFS_LIM2, {16'h0, 8'h08, up[k]}, 33'h0);
        apb(1, OFS_IEN, {28'h0, ie[k]}, 33'h0);
        r1[k] = (k == 0) ? 8'h8E : (k == 1) ? 8'h00 :
                (k == 2) ? 8'd125 + 8'({$random(seed)} % 17) : 8'({$random(seed)} % 125);
        tg1 <= t1[k]; tg2 <= t2[k]; rd1 <= r1[k]; rd2 <= r2[k];
        glitch <= (k == 2);
        evq.push_back(ev[k]);
        @(posedge pclk) glitch <= 1'b0;
      end
    end
    chk("events left", 33'h0, 33'(evq.size()));
    summarize();
  end
endmodule // tb_dvl_checker

bind dvl_checker dvl_checker_monitor #(.PERIOD_CYC(PERIOD_CYC), .WINDOW_CYC(WINDOW_CYC))
  dvl_checker_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .cpu_one_voltage_code_lines(cpu_one_voltage_code_lines),
  .cpu_two_voltage_code_lines(cpu_two_voltage_code_lines), .err_event(err_event), .irq(irq));

// ---- src/dvl_checker.sv ----
// Dynamic core-voltage limit checker with APB registers and interrupt
//
// Function
// - Channel one checks against CPU one code, channel two against CPU two.
// - Each 6-bit code maps to a nominal reference voltage.
// - Brief intermediate codes caused by line skew are ignored.
// - Indicated voltage is averaged over a 1.5 ms window.
// - Comparisons use the window average, never the instantaneous code.
// - Upper limit is average plus upper offset, lower is average minus lower.
// - A reading outside the limits raises an error event for its channel.
// - Comparisons run once every 100 ms period.
// - A window that saw an output-off code skips its check.
// - Upper check is dropped when average plus offset exceeds 1.5875 V.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dvl_checker import dvl_pkg::*; #(
  parameter int PERIOD_CYC = PERIOD_US * CLK_MHZ,
  parameter int WINDOW_CYC = WINDOW_US * CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Processor voltage codes
  input  wire logic [5:0]  cpu_one_voltage_code_lines,
  input  wire logic [5:0]  cpu_two_voltage_code_lines,
  // Converter readings
  input  wire logic [7:0]  core_voltage_input_one,
  input  wire logic [7:0]  core_voltage_input_two,
  input  wire logic        conv_valid,
  // Events and interrupt
  output logic [NCH-1:0]   err_event,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer timing
  localparam int SAMP_CYC = WINDOW_CYC >> SAMPLES_LOG2;
  localparam int WIN_AT   = PERIOD_CYC - WINDOW_CYC;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  dvl_state_t        state_reg;
  dvl_state_t        state_next;
  logic [31:0]       pcnt_reg;
  logic [31:0]       scnt_reg;
  logic [7:0]        nsamp_reg;
  logic [1:0]        ctrl_reg;
  dvl_lim_t          lim_reg [NCH];
  logic [7:0]        rd_reg [NCH];
  logic [3:0]        stat_reg;
  logic [3:0]        ien_reg;
  logic [NCH-1:0]    evt_reg;
  logic              irq_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  dvl_avg_t          avg_res [NCH];
  logic [5:0]        code_raw [NCH];
  logic [5:0]        code_flt [NCH];
  logic [7:0]        conv_in [NCH];
  logic [NCH-1:0]    hi_bad;
  logic [NCH-1:0]    lo_bad;
  logic [3:0]        stat_set;

  //////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from flops
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign err_event = evt_reg;
  assign irq       = irq_reg;

  assign code_raw[0] = cpu_one_voltage_code_lines;
  assign code_raw[1] = cpu_two_voltage_code_lines;
  assign conv_in[0]  = core_voltage_input_one;
  assign conv_in[1]  = core_voltage_input_two;

  //////////////////////////////////////////////////////////////////////////////
  // Period sequencer
  wire period_end = pcnt_reg == 32'(PERIOD_CYC - 1);
  wire win_start  = pcnt_reg == 32'(WIN_AT - 1);
  wire samp_tick  = (state_reg == ST_AVG) && (scnt_reg == 32'(SAMP_CYC - 1));
  wire last_samp  = samp_tick && (nsamp_reg == 8'hFF);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT: begin
        if (win_start) state_next = ST_AVG;
      end
      ST_AVG: begin
        if (last_samp) state_next = ST_CMP;
      end
      ST_CMP: begin
        state_next = ST_WAIT;
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  // Window sits at the tail of each period so the compare lands near its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_WAIT;
      pcnt_reg  <= 32'h0000_0000;
    end else if (ce) begin
      state_reg <= state_next;
      pcnt_reg  <= period_end ? 32'h0000_0000 : pcnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt_reg  <= 32'h0000_0000;
      nsamp_reg <= 8'h00;
    end else if (ce) begin
      if (state_reg != ST_AVG || samp_tick) scnt_reg <= 32'h0000_0000;
      else scnt_reg <= scnt_reg + 32'h0000_0001;
      if (state_reg != ST_AVG) nsamp_reg <= 8'h00;
      else if (samp_tick) nsamp_reg <= nsamp_reg + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel filter, averager and limit compare
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire [8:0] up_sum = {1'b0, avg_res[c].avg} + {1'b0, lim_reg[c].up};
      wire [8:0] lo_sum = {1'b0, rd_reg[c]} + {1'b0, lim_reg[c].lo};
      wire       armed  = ctrl_reg[c] && !avg_res[c].skip;

      dvl_vid_filter u_flt (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .code_in  (code_raw[c]),
        .code_out (code_flt[c])
      );

      dvl_vid_avg u_avg (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .restart (win_start),
        .sample  (samp_tick),
        .code    (code_flt[c]),
        .result  (avg_res[c])
      );

      // Upper check cannot reach above the converter cap, so it is dropped there
      assign hi_bad[c] = armed && (up_sum <= UPPER_CAP_LSB)
                         && ({1'b0, rd_reg[c]} > up_sum);
      // Lower limit is computed as reading plus offset to avoid underflow
      assign lo_bad[c] = armed && (lo_sum < {1'b0, avg_res[c].avg});

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rd_reg[c] <= 8'h00;
        end else if (ce && conv_valid) begin
          rd_reg[c] <= conv_in[c];
        end
      end
    end
  endgenerate

  // Only the averaged result feeds the compare, sampled in the compare state
  wire cmp_now = state_reg == ST_CMP;

  assign stat_set = cmp_now ? {lo_bad[1], hi_bad[1], lo_bad[0], hi_bad[0]} : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= '0;
    end else if (ce) begin
      evt_reg <= cmp_now ? (hi_bad | lo_bad) : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction

  wire access   = psel && penable;
  wire done     = access && pready_reg;
  wire wr_en    = done && pwrite;
  wire sel_ctrl = hit(paddr, OFS_CTRL);
  wire sel_lim1 = hit(paddr, OFS_LIM1);
  wire sel_lim2 = hit(paddr, OFS_LIM2);
  wire sel_stat = hit(paddr, OFS_STAT);
  wire sel_ien  = hit(paddr, OFS_IEN);
  wire sel_iclr = hit(paddr, OFS_ICLR);
  wire sel_avg  = hit(paddr, OFS_AVG);
  wire sel_read = hit(paddr, OFS_READ);
  wire mapped   = sel_ctrl | sel_lim1 | sel_lim2 | sel_stat |
                  sel_ien | sel_iclr | sel_avg | sel_read;
  wire [3:0] clr = (wr_en && sel_iclr) ? pwdata[3:0] : 4'h0;

  function automatic logic [31:0] lim_word(input dvl_lim_t l);
    return {16'h0000, l.lo, l.up};
  endfunction

  wire [31:0] rd_mux =
      sel_ctrl ? {30'h0, ctrl_reg} :
      sel_lim1 ? lim_word(lim_reg[0]) :
      sel_lim2 ? lim_word(lim_reg[1]) :
      sel_stat ? {28'h0, stat_reg} :
      sel_ien  ? {28'h0, ien_reg} :
      sel_avg  ? {14'h0, avg_res[1].skip, avg_res[0].skip,
                  avg_res[1].avg, avg_res[0].avg} :
      sel_read ? {16'h0000, rd_reg[1], rd_reg[0]} :
      32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (ce) begin
      pready_reg  <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !mapped;
      if (access && !pready_reg) prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers; software owns the offset margins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      ien_reg  <= IEN_RST;
      for (int i = 0; i < NCH; i++) lim_reg[i] <= '{up: UP_RST, lo: LO_RST};
    end else if (ce && wr_en) begin
      if (sel_ctrl) ctrl_reg <= pwdata[1:0];
      if (sel_ien) ien_reg <= pwdata[3:0];
      if (sel_lim1) lim_reg[0] <= '{up: pwdata[LIM_UP_POS +: 8],
                                    lo: pwdata[LIM_LO_POS +: 8]};
      if (sel_lim2) lim_reg[1] <= '{up: pwdata[LIM_UP_POS +: 8],
                                    lo: pwdata[LIM_LO_POS +: 8]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status and interrupt; a new event beats a clear in the same cycle
  wire [3:0] stat_next = (stat_reg & ~clr) | stat_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 4'h0;
      irq_reg  <= 1'b0;
    end else if (ce) begin
      stat_reg <= stat_next;
      irq_reg  <= |(stat_next & ien_reg);
    end
  end

endmodule // dvl_checker

// ---- src/dvl_pkg.sv ----
// Shared constants, types and decode functions of the dynamic core-voltage limit checker
package dvl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_MHZ       = 200;
  localparam int PERIOD_US     = 100000;
  localparam int WINDOW_US     = 1500;
  localparam int SKEW_NS       = 400;
  localparam int SKEW_CYC      = (SKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMPLES_LOG2  = 8;
  localparam int NCH           = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Voltage scale: one LSB is 6.25 mV, codes step by 12.5 mV
  localparam logic [7:0] VID_TOP_LSB   = 8'hFF;
  localparam logic [8:0] UPPER_CAP_LSB = 9'h0FE;
  localparam logic [4:0] VID_OFF_HI    = 5'h1F;
  localparam logic [5:0] VID_RST       = 6'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_LIM1  = 8'h04;
  localparam logic [7:0] OFS_LIM2  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IEN   = 8'h10;
  localparam logic [7:0] OFS_ICLR  = 8'h14;
  localparam logic [7:0] OFS_AVG   = 8'h18;
  localparam logic [7:0] OFS_READ  = 8'h1C;
  localparam int         LIM_UP_POS = 0;
  localparam int         LIM_LO_POS = 8;
  localparam int         AVG_SKIP_POS = 16;
  localparam logic [1:0] CTRL_RST  = 2'h3;
  localparam logic [7:0] UP_RST    = 8'h08;
  localparam logic [7:0] LO_RST    = 8'h08;
  localparam logic [3:0] IEN_RST   = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [7:0] up;
    logic [7:0] lo;
  } dvl_lim_t;

  typedef struct packed {
    logic [7:0] avg;
    logic       skip;
  } dvl_avg_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_AVG  = 3'b010,
    ST_CMP  = 3'b100
  } dvl_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Code decoding
  function automatic logic vid_is_off(input logic [5:0] code);
    return code[5:1] == VID_OFF_HI;
  endfunction

  function automatic logic [7:0] vid_to_lsb(input logic [5:0] code);
    return vid_is_off(code) ? 8'h00 : VID_TOP_LSB - {1'b0, code, 1'b0};
  endfunction

endpackage

// ---- src/dvl_vid_avg.sv ----
// Window averager of the voltage indicated by one code stream
`timescale 1ns/1ps
module dvl_vid_avg import dvl_pkg::*; (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // Control
  input  wire logic       restart,
  input  wire logic       sample,
  input  wire logic [5:0] code,
  // Result
  output dvl_avg_t        result
);

  logic [15:0] acc_reg;
  logic        off_reg;
  dvl_avg_t    res_reg;
  wire  [15:0] acc_next = acc_reg + {8'h00, vid_to_lsb(code)};
  wire         off_next = off_reg | vid_is_off(code);

  assign result = res_reg;

  // The sample count is a power of two, so the mean is a plain shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 16'h0000;
      off_reg <= 1'b0;
      res_reg <= '0;
    end else if (ce) begin
      if (restart) begin
        acc_reg <= 16'h0000;
        off_reg <= 1'b0;
      end else if (sample) begin
        acc_reg <= acc_next;
        off_reg <= off_next;
        res_reg <= '{avg: acc_next[15:8], skip: off_next};
      end
    end
  end

endmodule // dvl_vid_avg

// ---- src/dvl_vid_filter.sv ----
// Skew filter: a code is accepted only after it has held steady
`timescale 1ns/1ps
module dvl_vid_filter import dvl_pkg::*; (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // Code
  input  wire logic [5:0] code_in,
  output logic      [5:0] code_out
);

  logic [5:0] cand_reg;
  logic [7:0] cnt_reg;
  logic [5:0] out_reg;
  wire        same   = code_in == cand_reg;
  wire        stable = cnt_reg == 8'(SKEW_CYC - 1);

  assign code_out = out_reg;

  // Line skew makes short-lived mixtures of old and new bits; wait them out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_reg <= VID_RST;
      cnt_reg  <= 8'h00;
      out_reg  <= VID_RST;
    end else if (ce) begin
      cand_reg <= code_in;
      if (!same) cnt_reg <= 8'h00;
      else if (!stable) cnt_reg <= cnt_reg + 8'h01;
      if (same && stable) out_reg <= cand_reg;
    end
  end

endmodule // dvl_vid_filter
